// ==== src/scs_pkg.sv ====
package scs_pkg;
    // ***********************************
    // select codes and chain layout
    // ***********************************
    localparam int SEL_W = 4;
    localparam logic [3:0] SEL_CTRL = 4'h1;
    localparam logic [3:0] SEL_STAT = 4'h0;
    localparam logic [3:0] SEL_ADC = 4'h2;
    localparam logic [3:0] SEL_AUX = 4'h3;
    localparam int SEL_EXT_BIT = 3;
    localparam int NPROC = 8;
    localparam int NCFG = 7;
    localparam int NRATIO = 4;
    localparam int NVID = 4;
    localparam int CTRL_W = 16;
    localparam int CTRL_DIS_LSB = 0;
    localparam int CTRL_CFG_LSB = 8;
    localparam int CTRL_OVR_BIT = 15;
    localparam int STAT_W = 33;
    localparam int STAT_P12_LSB = 1;
    localparam int STAT_RATIO_LSB = 5;
    localparam int STAT_P34_LSB = 9;
    localparam int STAT_MEM2_BIT = 13;
    localparam int STAT_MEM1_BIT = 14;
    localparam int STAT_SPARE0_BIT = 15;
    localparam int STAT_SPARE1_BIT = 16;
    localparam int STAT_P58_LSB = 17;
    localparam int STAT_PRES_LSB = 25;
    localparam int AUX_W = 14;
    localparam int AUX_VID_LSB = 1;
    localparam int AUX_RB_LSB = 5;
    localparam int AUX_PF1_BIT = 12;
    localparam int AUX_PF2_BIT = 13;
    // ***********************************
    // wishbone register map
    // ***********************************
    localparam int WB_AW = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_OUTS = 8'h08;
    localparam logic CTRL_EN_RESET = 1'h1;
    // active chain, gray along none -> chain
    typedef enum logic [2:0] {
        CH_NONE = 3'h0,
        CH_STAT = 3'h1,
        CH_CTRL = 3'h3,
        CH_ADC = 3'h2,
        CH_AUX = 3'h6
    } scs_chain_t;
endpackage : scs_pkg

// ==== src/scs_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of pin levels
module scs_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk, // block clock
    input wire logic arst_n, // async reset
    input wire logic [W-1:0] d, // raw pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= meta_next;
            q <= q_next;
        end
    end
endmodule : scs_sync

// ==== src/scs_shift.sv ====
`timescale 1ns/1ps
// one serial chain: parallel capture, then shift toward bit 0
module scs_shift #(
    parameter int W = 16
) (
    input wire logic ref_clk, // block clock
    input wire logic arst_n, // async reset
    input wire logic load, // capture parallel value
    input wire logic [W-1:0] load_val, // value to capture
    input wire logic shift, // one serial clock edge
    input wire logic din, // serial data in
    output logic [W-1:0] q // chain contents
);
    logic [W-1:0] q_next;

    // load wins over shift; data enters at the top bit
    always_comb begin
        q_next = q;
        if (load) begin
            q_next = load_val;
        end else if (shift) begin
            q_next = {din, q[W-1:1]};
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= q_next;
        end
    end
endmodule : scs_shift

// ==== src/scs_top.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE_01 - decode four select lines so one local chain or none is connected
// RULE_02 - code 0001 connects the control chain: stops and config override
// RULE_03 - code 0000 connects the error, ratio and presence status chain
// RULE_04 - code 0010 connects the nineteen-channel voltage monitor converter
// RULE_05 - code 0011 connects the extra status chain with vid and readback
// RULE_06 - top select bit high: no local chain answers
// RULE_07 - fourth chain bit 12 is primary filter present, active low
// RULE_08 - fourth chain bit 13 is secondary filter present, active low
// RULE_09 - fitted stop-disable jumper forces every processor stop off
// RULE_10 - test jumpers are never readable or writable through any bus
// RULE_11 - second chain bits 5 to 8 carry ratio bits 3 down to 0
// RULE_12 - controller reads half-step open as integer ratios 3 to 7
// RULE_13 - controller adds one half when half-step jumper is fitted
// RULE_14 - controller takes core clock as ratio times 100 MHz
// RULE_15 - controller treats listed ratio jumper patterns as reserved
// RULE_16 - first chain: disables 0-7, config 8-14, override enable 15
// RULE_17 - fourth chain bits 5 to 11 return config values driven out
// RULE_18 - second chain returns per-processor thermal and internal errors
// RULE_19 - capture inputs when selected, shift on serial clock, update on end
// RULE_20 - fitted jumper reads 0, open jumper reads 1
// RULE_21 - management reset clears control outputs to inactive
module scs_top
    import scs_pkg::*;
(
    input wire logic ref_clk, // 20 MHz block clock
    input wire logic arst_n, // async reset, active low
    input wire logic mgmt_sclk, // serial clock pin
    input wire logic mgmt_mosi, // serial data in pin
    input wire logic [scs_pkg::SEL_W-1:0] mgmt_sel, // chain select pins
    input wire logic mgmt_reset_n, // management logic reset pin
    output logic mgmt_miso, // serial data out
    output logic mgmt_miso_oe, // high while driving data out
    input wire logic [scs_pkg::NPROC-1:0] proc_thermal_error_n, // per cpu
    input wire logic [scs_pkg::NPROC-1:0] proc_internal_error_n, // per cpu
    input wire logic [scs_pkg::NPROC-1:0] proc_present, // slot occupied
    input wire logic [1:0] mem_carrier_present_n, // [1] second, [0] primary
    input wire logic [scs_pkg::NRATIO-1:0] core_ratio_jumper, // [3] = bit3
    input wire logic [scs_pkg::NVID-1:0] cache_vid_conflict_n, // per pair
    input wire logic [scs_pkg::NCFG-1:0] config_readback, // driven config
    input wire logic primary_filter_present_n, // filter 1 fitted
    input wire logic secondary_filter_present_n, // filter 2 fitted
    input wire logic stop_jumper_n, // low when stop-disable fitted
    output logic [scs_pkg::NPROC-1:0] proc_disable, // stop outputs
    output logic [scs_pkg::NCFG-1:0] config_value, // config override data
    output logic config_override_enable, // apply config data
    output logic adc_cs_n, // converter select
    output logic adc_sclk, // converter serial clock
    output logic adc_mosi, // converter data in
    input wire logic adc_miso, // converter data out
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [scs_pkg::WB_AW-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o // acknowledge
);
    import scs_pkg::*;

    // ***********************************
    // pin synchronisers
    // ***********************************
    localparam int PIN_W = 2 * NPROC + NPROC + 2 + NRATIO + NVID + NCFG + 3;
    localparam int LNK_W = SEL_W + 4;

    logic [PIN_W-1:0] pins_s;
    logic [LNK_W-1:0] lnk_s;
    logic [NPROC-1:0] therm_s;
    logic [NPROC-1:0] ierr_s;
    logic [NPROC-1:0] pres_s;
    logic [1:0] mem_s;
    logic [NRATIO-1:0] ratio_s;
    logic [NVID-1:0] vid_s;
    logic [NCFG-1:0] rb_s;
    logic pf1_s;
    logic pf2_s;
    logic stop_open_s;
    logic sclk_s;
    logic mosi_s;
    logic mgmt_rst_n_s;
    logic adc_miso_s;
    logic [SEL_W-1:0] sel_s;

    // board status levels change slowly; one bundle keeps area low
    scs_sync #(.W(PIN_W)) u_pin_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .d({proc_thermal_error_n, proc_internal_error_n, proc_present,
            mem_carrier_present_n, core_ratio_jumper, cache_vid_conflict_n,
            config_readback, primary_filter_present_n,
            secondary_filter_present_n, stop_jumper_n}),
        .q(pins_s)
    );

    scs_sync #(.W(LNK_W)) u_lnk_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .d({mgmt_sel, mgmt_sclk, mgmt_mosi, mgmt_reset_n, adc_miso}),
        .q(lnk_s)
    );

    assign {therm_s, ierr_s, pres_s, mem_s, ratio_s, vid_s, rb_s,
            pf1_s, pf2_s, stop_open_s} = pins_s;
    assign {sel_s, sclk_s, mosi_s, mgmt_rst_n_s, adc_miso_s} = lnk_s;

    // ***********************************
    // select decode
    // ***********************************
    function automatic scs_chain_t scs_decode(input logic [SEL_W-1:0] s,
                                              input logic en);
        scs_chain_t c;
        c = CH_NONE;
        if (en && !s[SEL_EXT_BIT]) begin // RULE_06
            unique case (s)
                SEL_CTRL: c = CH_CTRL; // RULE_02
                SEL_STAT: c = CH_STAT; // RULE_03
                SEL_ADC: c = CH_ADC; // RULE_04
                SEL_AUX: c = CH_AUX; // RULE_05
                default: c = CH_NONE;
            endcase
        end
        return c;
    endfunction : scs_decode

    logic ctrl_en_reg;
    logic ctrl_en_next;
    scs_chain_t active_reg;
    scs_chain_t active_next;
    scs_chain_t want;
    logic sclk_d_reg;
    logic sclk_d_next;
    logic sclk_rise;
    logic enter;

    // select lines are sampled, not strobed: a slow skewed code change
    // may briefly pass through another chain, so masters settle select
    // before toggling the serial clock
    always_comb begin
        want = scs_decode(sel_s, ctrl_en_reg && mgmt_rst_n_s); // RULE_01
        active_next = want;
        enter = (want != active_reg);
        sclk_d_next = sclk_s;
        sclk_rise = sclk_s && !sclk_d_reg;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_reg <= CH_NONE;
            sclk_d_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
            sclk_d_reg <= sclk_d_next;
        end
    end

    // ***********************************
    // capture values of the chains
    // ***********************************
    logic [CTRL_W-1:0] ctrl_cap;
    logic [STAT_W-1:0] stat_cap;
    logic [AUX_W-1:0] aux_cap;

    // jumper levels pass unchanged: fitted pulls low
    always_comb begin
        ctrl_cap = {config_override_enable, config_value, proc_disable};
        stat_cap = '1;
        for (int i = 0; i < 2; i++) begin
            stat_cap[STAT_P12_LSB + 2 * i] = therm_s[i]; // RULE_18
            stat_cap[STAT_P12_LSB + 2 * i + 1] = ierr_s[i];
            stat_cap[STAT_P34_LSB + 2 * i] = therm_s[i + 2];
            stat_cap[STAT_P34_LSB + 2 * i + 1] = ierr_s[i + 2];
        end
        for (int i = 0; i < 4; i++) begin
            stat_cap[STAT_P58_LSB + 2 * i] = therm_s[i + 4];
            stat_cap[STAT_P58_LSB + 2 * i + 1] = ierr_s[i + 4];
        end
        for (int i = 0; i < NRATIO; i++) begin
            stat_cap[STAT_RATIO_LSB + i] = ratio_s[NRATIO - 1 - i]; // RULE_11 RULE_20
        end
        stat_cap[STAT_MEM2_BIT] = mem_s[1];
        stat_cap[STAT_MEM1_BIT] = mem_s[0];
        stat_cap[STAT_SPARE0_BIT] = 1'b1;
        stat_cap[STAT_SPARE1_BIT] = 1'b1;
        stat_cap[STAT_PRES_LSB +: NPROC] = pres_s;
        aux_cap = '1;
        aux_cap[AUX_VID_LSB +: NVID] = vid_s;
        aux_cap[AUX_RB_LSB +: NCFG] = rb_s; // RULE_17
        aux_cap[AUX_PF1_BIT] = pf1_s; // RULE_07
        aux_cap[AUX_PF2_BIT] = pf2_s; // RULE_08
    end

    // ***********************************
    // shift chains
    // ***********************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [STAT_W-1:0] stat_q;
    logic [AUX_W-1:0] aux_q;
    logic ld_ctrl;
    logic ld_stat;
    logic ld_aux;
    logic sh_ctrl;
    logic sh_stat;
    logic sh_aux;

    // capture on entry; shifting waits until entry has settled
    always_comb begin
        ld_ctrl = enter && (want == CH_CTRL); // RULE_19
        ld_stat = enter && (want == CH_STAT);
        ld_aux = enter && (want == CH_AUX);
        sh_ctrl = !enter && (active_reg == CH_CTRL) && sclk_rise;
        sh_stat = !enter && (active_reg == CH_STAT) && sclk_rise;
        sh_aux = !enter && (active_reg == CH_AUX) && sclk_rise;
    end

    scs_shift #(.W(CTRL_W)) u_ctrl_chain (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(ld_ctrl),
        .load_val(ctrl_cap),
        .shift(sh_ctrl),
        .din(mosi_s),
        .q(ctrl_q)
    );

    scs_shift #(.W(STAT_W)) u_stat_chain (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(ld_stat),
        .load_val(stat_cap),
        .shift(sh_stat),
        .din(mosi_s),
        .q(stat_q)
    );

    scs_shift #(.W(AUX_W)) u_aux_chain (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(ld_aux),
        .load_val(aux_cap),
        .shift(sh_aux),
        .din(mosi_s),
        .q(aux_q)
    );

    // ***********************************
    // control outputs
    // ***********************************
    logic [CTRL_W-1:0] latch_reg;
    logic [CTRL_W-1:0] latch_next;
    logic [NPROC-1:0] dis_next;
    logic [NCFG-1:0] cfg_next;
    logic ovr_next;

    // outputs load on control chain release; management reset clears them, a fitted stop jumper masks the stops
    always_comb begin
        latch_next = latch_reg;
        if (!mgmt_rst_n_s) begin
            latch_next = '0; // RULE_21
        end else if (active_reg == CH_CTRL && want != CH_CTRL) begin
            latch_next = ctrl_q; // RULE_19
        end
        dis_next = latch_reg[CTRL_DIS_LSB +: NPROC] & {NPROC{stop_open_s}}; // RULE_09
        cfg_next = latch_reg[CTRL_CFG_LSB +: NCFG]; // RULE_16
        ovr_next = latch_reg[CTRL_OVR_BIT];
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_reg <= '0;
            proc_disable <= '0;
            config_value <= '0;
            config_override_enable <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            proc_disable <= dis_next;
            config_value <= cfg_next;
            config_override_enable <= ovr_next;
        end
    end

    // ***********************************
    // serial out and converter path
    // ***********************************
    logic miso_next;
    logic oe_next;
    logic cs_n_next;
    logic asclk_next;

    // undriven for 1xxx so the other carrier may answer
    always_comb begin
        miso_next = 1'b0;
        unique case (active_reg)
            CH_CTRL: miso_next = ctrl_q[0];
            CH_STAT: miso_next = stat_q[0];
            CH_AUX: miso_next = aux_q[0];
            CH_ADC: miso_next = adc_miso_s;
            CH_NONE: miso_next = 1'b0;
        endcase
        oe_next = (active_reg != CH_NONE); // RULE_01
        cs_n_next = (active_reg != CH_ADC); // RULE_04
        asclk_next = (active_reg == CH_ADC) && sclk_s;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmt_miso <= 1'b0;
            mgmt_miso_oe <= 1'b0;
            adc_cs_n <= 1'b1;
            adc_sclk <= 1'b0;
            adc_mosi <= 1'b0;
        end else begin
            mgmt_miso <= miso_next;
            mgmt_miso_oe <= oe_next;
            adc_cs_n <= cs_n_next;
            adc_sclk <= asclk_next;
            adc_mosi <= mosi_s;
        end
    end

    // ***********************************
    // wishbone slave
    // ***********************************
    logic ack_next;
    logic [31:0] rdat_next;
    logic wb_hit;

    // one wait state; no jumper level is ever placed on this bus
    always_comb begin
        wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
        ack_next = wb_hit;
        ctrl_en_next = ctrl_en_reg;
        rdat_next = '0;
        if (wb_hit && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
            ctrl_en_next = wb_dat_i[0];
        end
        if (wb_hit && !wb_we_i) begin
            unique case (wb_adr_i)
                ADR_CTRL: rdat_next[0] = ctrl_en_reg;
                ADR_STATUS: rdat_next[7:0] = {mgmt_rst_n_s, active_reg, sel_s}; // RULE_10
                ADR_OUTS: rdat_next[CTRL_W-1:0] =
                    {config_override_enable, config_value, proc_disable};
                default: rdat_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl_en_reg <= CTRL_EN_RESET;
        end else begin
            wb_ack_o <= ack_next;
            wb_dat_o <= rdat_next;
            ctrl_en_reg <= ctrl_en_next;
        end
    end

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_leave_ctrl;
        active_reg == CH_CTRL && want != CH_CTRL && mgmt_rst_n_s;
    endsequence
    sequence s_enter_aux;
        active_reg != CH_AUX && want == CH_AUX;
    endsequence

    AST_EXT_NONE: assert property (sel_s[SEL_EXT_BIT] |=> active_reg == CH_NONE) // RULE_06
        else $error("local chain active with top select bit set");
    AST_CTRL_SEL: assert property (sel_s == SEL_CTRL && ctrl_en_reg && mgmt_rst_n_s
        |=> active_reg == CH_CTRL) // RULE_02
        else $error("code 0001 did not select control chain");
    AST_STAT_SEL: assert property (sel_s == SEL_STAT && ctrl_en_reg && mgmt_rst_n_s
        |=> active_reg == CH_STAT) // RULE_03
        else $error("code 0000 did not select status chain");
    AST_ADC_SEL: assert property (active_reg == CH_ADC |=> !adc_cs_n) // RULE_04
        else $error("converter not selected");
    AST_AUX_SEL: assert property (sel_s == SEL_AUX && ctrl_en_reg && mgmt_rst_n_s
        |=> active_reg == CH_AUX) // RULE_05
        else $error("code 0011 did not select fourth chain");
    AST_OE_MATCH: assert property (mgmt_miso_oe == ($past(active_reg) != CH_NONE)) // RULE_01
        else $error("data out enable disagrees with selection");
    AST_PF1: assert property (s_enter_aux |=> aux_q[AUX_PF1_BIT] == $past(pf1_s)) // RULE_07
        else $error("primary filter presence not captured");
    AST_PF2: assert property (s_enter_aux |=> aux_q[AUX_PF2_BIT] == $past(pf2_s)) // RULE_08
        else $error("secondary filter presence not captured");
    AST_STOP_MASK: assert property (!stop_open_s [*2] |=> proc_disable == '0) // RULE_09
        else $error("stop output active with jumper fitted");
    AST_RATIO: assert property (enter && want == CH_STAT
        |=> stat_q[STAT_RATIO_LSB] == $past(ratio_s[NRATIO-1])) // RULE_11
        else $error("ratio bit 3 not on chain bit 5");
    AST_UPDATE: assert property (s_leave_ctrl |=> latch_reg == $past(ctrl_q)
        ##1 config_override_enable == latch_reg[CTRL_OVR_BIT]) // RULE_16
        else $error("control outputs not updated on release");
    AST_MGMT_RST: assert property (!mgmt_rst_n_s |-> ##2 config_override_enable == 1'b0
        && proc_disable == '0) // RULE_21
        else $error("management reset left outputs active");
endmodule : scs_top

// ==== tb/scs_mgmt_model.sv ====
`timescale 1ns/1ps
// ****
// management serial master
// ****
module scs_mgmt_model (
    input wire logic ref_clk, // block clock
    input wire logic miso, // data from block
    output logic sclk, // serial clock
    output logic mosi, // data to block
    output logic [3:0] sel // chain select
);
    // idle on an off-board code so no local chain is entered
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        sel = 4'h8;
    end
    // one frame, bit0 first; the clock stands still outside frames
    task automatic xfer(input logic [3:0] c, input int n, input logic [32:0] d,
        output logic [32:0] q);
        q = '0;
        @(posedge ref_clk);
        sel <= c;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            mosi <= d[i];
            repeat (4) @(posedge ref_clk);
            q[i] = miso; // sampled just before the rise
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        sel <= 4'h8;
        mosi <= ~mosi; // released line keeps no stale level
        repeat (8) @(posedge ref_clk);
    endtask : xfer
endmodule : scs_mgmt_model

// ==== tb/test_serial_chain_select_status.sv ====
`timescale 1ns/1ps
// ****
// chain select bench
// ****
module test_serial_chain_select_status;
    import scs_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, mosi, miso, oe, mrst_n, stop_n, cyc, stb, we, ack, ovr, cs_n, pf1, pf2;
    logic [3:0] sel, ratio, vid, wsel;
    logic [7:0] tt, ie, pres, dis, adr;
    logic [6:0] rb, cfg;
    logic [1:0] mem;
    logic [31:0] wdat, rdat;
    logic [32:0] q, e;
    logic oe_seen, cs_seen;
    logic asclk, amosi, asclk_d;
    logic [7:0] ashift = 8'h00;
    int errors = 0;
    int n_checks = 0;
    int cyc_cnt = 0;
    always #25 ref_clk = ~ref_clk;
    scs_top scs_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .mgmt_sclk(sclk),
        .mgmt_mosi(mosi), .mgmt_sel(sel), .mgmt_reset_n(mrst_n), .mgmt_miso(miso),
        .mgmt_miso_oe(oe), .proc_thermal_error_n(tt), .proc_internal_error_n(ie),
        .proc_present(pres), .mem_carrier_present_n(mem), .core_ratio_jumper(ratio),
        .cache_vid_conflict_n(vid), .config_readback(rb), .primary_filter_present_n(pf1),
        .secondary_filter_present_n(pf2), .stop_jumper_n(stop_n), .proc_disable(dis),
        .config_value(cfg), .config_override_enable(ovr), .adc_cs_n(cs_n),
        .adc_sclk(asclk), .adc_mosi(amosi), .adc_miso(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    scs_mgmt_model scs_mgmt_model_i (.ref_clk(ref_clk), .miso(miso), .sclk(sclk),
        .mosi(mosi), .sel(sel));
    // flags catch short pulses between the bench's own checks
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (oe === 1'b1) oe_seen <= 1'b1;
        if (cs_n === 1'b0) cs_seen <= 1'b1;
        // converter side: take its data line on each rise of its clock
        asclk_d <= asclk;
        if (asclk && !asclk_d) ashift <= {amosi, ashift[7:1]};
        if (cyc_cnt == 20000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [32:0] x, input logic [32:0] g);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic xfer(input logic [3:0] c, input int n, input logic [32:0] d);
        oe_seen <= 1'b0;
        cs_seen <= 1'b0;
        scs_mgmt_model_i.xfer(c, n, d, q);
    endtask : xfer
    // classic single cycle; ack is sampled at the edge, then released
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wsel <= 4'hf;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        chk("wb ack", 1'b1, ack);
        q = {1'b0, rdat};
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wbx
    // controller view of the ratio bits; 0 marks a reserved pattern
    function automatic int core_mhz(input logic [3:0] r);
        int m;
        case ({~r[3], ~r[1], ~r[0]})
            3'b001: m = 300;
            3'b010: m = 400;
            3'b011: m = 500;
            3'b100: m = 600;
            3'b101: m = 700;
            default: m = 0;
        endcase
        if (m != 0 && !r[2]) begin
            m = m + 50;
        end
        return m;
    endfunction : core_mhz
    task automatic t_ctrl;
        xfer(4'h1, 16, 33'h9a5c);
        chk("ctrl capture", 16'h0, q[15:0]);
        chk("ctrl outs", 16'h9a5c, {ovr, cfg, dis});
        chk("ctrl oe", 1'b1, oe_seen);
        wbx(1'b0, ADR_OUTS, 32'h0);
        chk("outs reg", 32'h9a5c, q);
        xfer(4'h1, 16, 33'h9a5c);
        chk("ctrl readback", 16'h9a5c, q[15:0]);
    endtask : t_ctrl
    task automatic t_stop;
        stop_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("stop masked", 15'h1a00, {cfg, dis});
        stop_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("stop back", 8'h5c, dis);
    endtask : t_stop
    task automatic t_stat;
        int b;
        xfer(SEL_STAT, 33, 33'h0);
        e = '0;
        e[0] = 1'b1;
        e[16:13] = {2'b11, mem[0], mem[1]};
        e[32:25] = pres;
        for (int p = 0; p < 8; p++) begin
            b = (p < 2) ? 1 + 2 * p : (p < 4) ? 5 + 2 * p : 9 + 2 * p;
            e[b] = tt[p];
            e[b + 1] = ie[p];
        end
        for (int i = 0; i < 4; i++) e[5 + i] = ratio[3 - i];
        chk("status chain", e, q);
        chk("reserved ratio", 0, core_mhz({q[5], q[6], q[7], q[8]}));
        ratio <= 4'h8;
        xfer(SEL_STAT, 33, 33'h0);
        chk("ratio bits", 4'h8, {q[5], q[6], q[7], q[8]});
        chk("core clock", 550, core_mhz({q[5], q[6], q[7], q[8]}));
    endtask : t_stat
    task automatic t_aux;
        xfer(SEL_AUX, 14, 33'h0);
        chk("aux chain", {pf2, pf1, rb, vid, 1'b1}, q[13:0]);
    endtask : t_aux
    task automatic t_adc;
        xfer(SEL_ADC, 8, 33'h5a);
        chk("adc selected", 1'b1, cs_seen);
        chk("adc released", 1'b1, cs_n);
        chk("adc data in", 8'h5a, ashift);
        chk("adc data out", 8'hff, q[7:0]);
    endtask : t_adc
    // off-board codes and the unused local code 0100 must leave the outputs alone; a disabled block must keep data out undriven
    task automatic t_none;
        logic [3:0] c [3] = '{4'h8, 4'hc, 4'h4};
        for (int i = 0; i < 3; i++) begin
            xfer(c[i], 16, 33'h0f0f);
            chk("offboard oe", 1'b0, oe_seen);
            chk("offboard outs", 16'h9a5c, {ovr, cfg, dis});
        end
        wbx(1'b1, ADR_CTRL, 32'h0);
        xfer(4'h1, 16, 33'h0f0f);
        chk("disabled oe", 1'b0, oe_seen);
        wbx(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        wbx(1'b1, ADR_CTRL, 32'h1);
        wbx(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl reg", 32'h1, q);
        wbx(1'b0, ADR_STATUS, 32'h0);
        chk("status reg", 32'h88, q);
    endtask : t_none
    task automatic t_mrst;
        mrst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("mgmt reset", 16'h0, {ovr, cfg, dis});
        mrst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : t_mrst
    initial begin
        {mrst_n, stop_n, cyc, stb, we, pf1, pf2} = 7'b1100001;
        {tt, ie, pres, adr} = 32'h5ac39600;
        {mem, ratio, vid, wsel, rb} = 21'h1a_6f35 >> 0;
        wdat = 32'h0;
        oe_seen = 1'b0;
        cs_seen = 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("reset outs", 17'h10000, {cs_n, ovr, cfg, dis});
        t_ctrl();
        t_stop();
        t_none();
        t_stat();
        t_aux();
        t_adc();
        t_mrst();
        results();
    end
endmodule : test_serial_chain_select_status
